// >>> rtl/afss_top.sv
`timescale 1ns/100ps
module afss_top #(
    parameter int DEPTH = afss_pkg::AFSS_DEPTH
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic conv_trig,
    output afss_pkg::afss_req_t adc_req,
    input wire logic adc_done,
    input wire logic [afss_pkg::AFSS_DW-1:0] adc_data,
    output logic irq
);
    import afss_pkg::*;

    localparam int AW = $clog2(DEPTH);
    localparam int SW = AFSS_DW + AFSS_CHW;
    localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
    localparam logic [AW:0] ONE = (AW+1)'(1);

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic rd_ok;
        logic run;
        logic fifo_en;
        logic scan;
        logic recycle;
        logic [AFSS_CHW-1:0] lo;
        logic [AFSS_CHW-1:0] hi;
        logic [AW:0] thr;
        logic [AFSS_NEV-1:0] status;
        logic [AFSS_NEV-1:0] mask;
        logic irq;
        afss_st_t st;
        logic [AFSS_CHW-1:0] ch;
        logic scan_busy;
        afss_req_t req;
        logic [DEPTH-1:0][SW-1:0] mem;
        logic [AW-1:0] rd;
        logic [AW-1:0] wr;
        logic [AW:0] cnt;
    } afss_state_t;

    afss_state_t r;
    afss_state_t n;

    logic setup;
    logic acc;
    logic wr_acc;
    logic rd_acc;
    logic push;
    logic pop;
    logic thr_hit;
    logic [AFSS_NEV-1:0] ev;
    logic [AFSS_NEV-1:0] w1c;
    logic [AFSS_CHW-1:0] ch_next;

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        n = r;
        ev = '0;
        w1c = '0;
        push = 1'b0;
        pop = 1'b0;
        n.req.start = 1'b0;
        n.pready = 1'b0;
        n.pslverr = 1'b0;
        setup = psel & ~penable;
        acc = psel & penable & r.pready;
        wr_acc = acc & pwrite;
        rd_acc = acc & ~pwrite;
        ch_next = (r.ch == r.hi) ? r.lo : r.ch + AFSS_CHW'(1);

        // Sequencer: one request per trigger, or a burst over the range
        unique case (r.st)
            AFSS_S_IDLE: begin
                if (conv_trig && r.run) begin
                    n.st = AFSS_S_WAIT;
                    n.req.start = 1'b1;
                    if (r.scan) begin
                        n.ch = r.lo;
                        n.req.channel = r.lo;
                        n.scan_busy = 1'b1;
                    end else begin
                        n.req.channel = r.ch;
                    end
                end
            end
            AFSS_S_WAIT: begin
                // A pulse while busy cannot be honoured; flag it
                if (conv_trig) begin
                    ev[AFSS_EV_OVR] = 1'b1;
                end
                if (adc_done) begin
                    push = 1'b1;
                    if (r.scan) begin
                        if (r.ch == r.hi) begin
                            n.scan_busy = 1'b0;
                            n.st = AFSS_S_IDLE;
                            ev[AFSS_EV_SCAN] = ~r.fifo_en;
                        end else begin
                            n.ch = r.ch + AFSS_CHW'(1);
                            n.req.channel = r.ch + AFSS_CHW'(1);
                            n.req.start = 1'b1;
                        end
                    end else begin
                        n.ch = ch_next;
                        n.st = AFSS_S_IDLE;
                        ev[AFSS_EV_CONV] = ~r.fifo_en;
                    end
                end
            end
        endcase

        // Sample store; a full store drops the new sample
        if (push) begin
            if (r.cnt == FULL) begin
                ev[AFSS_EV_OVR] = 1'b1;
                push = 1'b0;
            end else begin
                n.mem[r.wr] = {r.ch, adc_data};
                n.wr = r.wr + AW'(1);
            end
        end
        if (rd_acc && paddr == AFSS_OFS_DATA && r.rd_ok) begin
            pop = 1'b1;
            n.rd = r.rd + AW'(1);
        end
        if (push && !pop) begin
            n.cnt = r.cnt + ONE;
        end else if (pop && !push) begin
            n.cnt = r.cnt - ONE;
        end

        // Level condition re-sets the bit each cycle except during a busy scan, so outside a busy scan with FIFO mode on it holds while at or above a nonzero threshold
        thr_hit = r.fifo_en && r.thr != '0 && r.cnt >= r.thr;
        if (thr_hit && !(r.scan && r.scan_busy)) begin
            ev[AFSS_EV_THR] = 1'b1;
        end

        // Register writes
        if (wr_acc) begin
            unique case (paddr)
                AFSS_OFS_CTRL: begin
                    n.run = pwdata[AFSS_CTRL_RUN];
                    n.fifo_en = pwdata[AFSS_CTRL_FIFO];
                    n.scan = pwdata[AFSS_CTRL_SCAN];
                    n.recycle = pwdata[AFSS_CTRL_RECYCLE];
                end
                AFSS_OFS_RANGE: begin
                    n.lo = pwdata[AFSS_RANGE_LO +: AFSS_CHW];
                    n.hi = pwdata[AFSS_RANGE_HI +: AFSS_CHW];
                    n.ch = pwdata[AFSS_RANGE_LO +: AFSS_CHW];
                end
                AFSS_OFS_THRESH: n.thr = pwdata[AW:0];
                AFSS_OFS_STATUS: w1c = pwdata[AFSS_NEV-1:0];
                AFSS_OFS_MASK: n.mask = pwdata[AFSS_NEV-1:0];
                default: ;
            endcase
            // Cancel stops sequencing and discards stored samples
            if (paddr == AFSS_OFS_CTRL && pwdata[AFSS_CTRL_CANCEL]) begin
                n.run = 1'b0;
                n.st = AFSS_S_IDLE;
                n.scan_busy = 1'b0;
                n.req.start = 1'b0;
                n.ch = r.lo;
                n.cnt = '0;
                n.rd = '0;
                n.wr = '0;
            end
        end

        // Set wins over a same-cycle clear
        n.status = (r.status & ~w1c) | ev;
        n.irq = |(n.status & n.mask);

        // Read data is latched in the setup cycle; zero wait states
        if (setup) begin
            n.pready = 1'b1;
            n.prdata = '0;
            n.rd_ok = 1'b0;
            unique case (paddr)
                AFSS_OFS_CTRL: begin
                    n.prdata[AFSS_CTRL_RUN] = r.run;
                    n.prdata[AFSS_CTRL_FIFO] = r.fifo_en;
                    n.prdata[AFSS_CTRL_SCAN] = r.scan;
                    n.prdata[AFSS_CTRL_RECYCLE] = r.recycle;
                end
                AFSS_OFS_RANGE: begin
                    n.prdata[AFSS_RANGE_LO +: AFSS_CHW] = r.lo;
                    n.prdata[AFSS_RANGE_HI +: AFSS_CHW] = r.hi;
                end
                AFSS_OFS_THRESH: n.prdata[AW:0] = r.thr;
                AFSS_OFS_STATUS: n.prdata[AFSS_NEV-1:0] = r.status;
                AFSS_OFS_MASK: n.prdata[AFSS_NEV-1:0] = r.mask;
                AFSS_OFS_DATA: begin
                    // Empty store reads zero and pops nothing
                    if (r.cnt != '0) begin
                        n.rd_ok = 1'b1;
                        n.prdata[AFSS_DW-1:0] = r.mem[r.rd][AFSS_DW-1:0];
                        n.prdata[AFSS_DATA_CH +: AFSS_CHW] = r.mem[r.rd][SW-1 -: AFSS_CHW];
                    end
                end
                AFSS_OFS_LEVEL: begin
                    n.prdata[AW:0] = r.cnt;
                    n.prdata[AFSS_LEVEL_CH +: AFSS_CHW] = r.ch;
                    n.prdata[AFSS_LEVEL_BUSY] = (r.st == AFSS_S_WAIT);
                    n.prdata[AFSS_LEVEL_SCAN] = r.scan_busy;
                end
                default: n.pslverr = 1'b1;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
            r.mask <= AFSS_MASK_RST;
            r.ch <= AFSS_CH_RST;
            r.st <= AFSS_S_IDLE;
        end else begin
            r <= n;
        end
    end

    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign adc_req = r.req;
    assign irq = r.irq;

    ////////////////////////////////////////////////////////////////////////////////
    property p_single_one;
        @(posedge pclk) disable iff (!presetn)
        (r.st == AFSS_S_IDLE && conv_trig && r.run && !r.scan && !wr_acc)
            |=> adc_req.start && adc_req.channel == $past(r.ch) ##1 !adc_req.start;
    endproperty
    a_single_one: assert property (p_single_one) else $error("single trigger request wrong");

    property p_advance;
        @(posedge pclk) disable iff (!presetn)
        (r.st == AFSS_S_WAIT && adc_done && !r.scan && !wr_acc)
            |=> r.ch == (($past(r.ch) == r.hi) ? r.lo : $past(r.ch) + AFSS_CHW'(1));
    endproperty
    a_advance: assert property (p_advance) else $error("channel did not advance or wrap");

    property p_scan_start;
        @(posedge pclk) disable iff (!presetn)
        (r.st == AFSS_S_IDLE && conv_trig && r.run && r.scan && !wr_acc)
            |=> adc_req.start && adc_req.channel == r.lo && r.scan_busy;
    endproperty
    a_scan_start: assert property (p_scan_start) else $error("scan did not start at low");

    property p_scan_step;
        @(posedge pclk) disable iff (!presetn)
        (r.st == AFSS_S_WAIT && adc_done && r.scan && r.ch != r.hi && !wr_acc)
            |=> adc_req.start && adc_req.channel == $past(r.ch) + AFSS_CHW'(1);
    endproperty
    a_scan_step: assert property (p_scan_step) else $error("scan did not step upward");

    property p_thr_irq;
        @(posedge pclk) disable iff (!presetn)
        (thr_hit && !r.scan && r.mask[AFSS_EV_THR]) |=> irq;
    endproperty
    a_thr_irq: assert property (p_thr_irq) else $error("threshold request missing");

    property p_scan_hold;
        @(posedge pclk) disable iff (!presetn)
        (!r.status[AFSS_EV_THR] && r.scan && r.scan_busy) |=> !r.status[AFSS_EV_THR];
    endproperty
    a_scan_hold: assert property (p_scan_hold) else $error("threshold set mid scan");

    property p_thr_stay;
        @(posedge pclk) disable iff (!presetn)
        (thr_hit && !r.scan) |=> r.status[AFSS_EV_THR] [*1] ##0 r.status[AFSS_EV_THR];
    endproperty
    a_thr_stay: assert property (p_thr_stay) else $error("threshold bit dropped early");

    property p_conv_ev;
        @(posedge pclk) disable iff (!presetn)
        (r.st == AFSS_S_WAIT && adc_done && !r.scan && !r.fifo_en)
            |=> r.status[AFSS_EV_CONV];
    endproperty
    a_conv_ev: assert property (p_conv_ev) else $error("conversion event missing");

    property p_scan_ev;
        @(posedge pclk) disable iff (!presetn)
        (r.st == AFSS_S_WAIT && adc_done && r.scan && r.ch == r.hi && !r.fifo_en)
            |=> r.status[AFSS_EV_SCAN] && !r.scan_busy;
    endproperty
    a_scan_ev: assert property (p_scan_ev) else $error("scan event missing");

    property p_cancel;
        @(posedge pclk) disable iff (!presetn)
        (wr_acc && paddr == AFSS_OFS_CTRL && pwdata[AFSS_CTRL_CANCEL])
            |=> !r.run && r.cnt == '0 && r.st == AFSS_S_IDLE ##1 !adc_req.start;
    endproperty
    a_cancel: assert property (p_cancel) else $error("cancel did not stop");

    property p_mode_flags;
        @(posedge pclk) disable iff (!presetn)
        (wr_acc && paddr == AFSS_OFS_CTRL)
            |=> r.fifo_en == $past(pwdata[AFSS_CTRL_FIFO])
                && r.scan == $past(pwdata[AFSS_CTRL_SCAN])
                && r.recycle == $past(pwdata[AFSS_CTRL_RECYCLE]);
    endproperty
    a_mode_flags: assert property (p_mode_flags) else $error("mode flags not stored");

    // A pulse while busy must not launch a second conversion
    property p_busy_trig;
        @(posedge pclk) disable iff (!presetn)
        (r.st == AFSS_S_WAIT && conv_trig && !adc_done)
            |=> !adc_req.start && r.status[AFSS_EV_OVR];
    endproperty
    a_busy_trig: assert property (p_busy_trig) else $error("busy trigger not refused");

endmodule

// >>> rtl/afss_pkg.sv
package afss_pkg;

    // Converter word and channel widths, sample store depth
    localparam int AFSS_DW = 12;
    localparam int AFSS_CHW = 4;
    localparam int AFSS_DEPTH = 16;

    // Register byte offsets
    localparam logic [7:0] AFSS_OFS_CTRL = 8'h00;
    localparam logic [7:0] AFSS_OFS_RANGE = 8'h04;
    localparam logic [7:0] AFSS_OFS_THRESH = 8'h08;
    localparam logic [7:0] AFSS_OFS_STATUS = 8'h0C;
    localparam logic [7:0] AFSS_OFS_MASK = 8'h10;
    localparam logic [7:0] AFSS_OFS_DATA = 8'h14;
    localparam logic [7:0] AFSS_OFS_LEVEL = 8'h18;

    // Control register fields
    localparam int AFSS_CTRL_RUN = 0;
    localparam int AFSS_CTRL_FIFO = 1;
    localparam int AFSS_CTRL_SCAN = 2;
    localparam int AFSS_CTRL_RECYCLE = 3;
    localparam int AFSS_CTRL_CANCEL = 4;

    // Range register fields
    localparam int AFSS_RANGE_LO = 0;
    localparam int AFSS_RANGE_HI = 8;

    // Data and level register fields
    localparam int AFSS_DATA_CH = 16;
    localparam int AFSS_LEVEL_CH = 16;
    localparam int AFSS_LEVEL_BUSY = 24;
    localparam int AFSS_LEVEL_SCAN = 25;

    // Status and mask bits
    localparam int AFSS_NEV = 4;
    localparam int AFSS_EV_CONV = 0;
    localparam int AFSS_EV_SCAN = 1;
    localparam int AFSS_EV_THR = 2;
    localparam int AFSS_EV_OVR = 3;

    // Reset values
    localparam logic [AFSS_NEV-1:0] AFSS_MASK_RST = 4'h0;
    localparam logic [AFSS_CHW-1:0] AFSS_CH_RST = 4'h0;

    typedef enum logic [0:0] {
        AFSS_S_IDLE = 1'b0,
        AFSS_S_WAIT = 1'b1
    } afss_st_t;

    typedef struct packed {
        logic start;
        logic [AFSS_CHW-1:0] channel;
    } afss_req_t;

endpackage

// >>> tb/afss_adc_model.sv
`timescale 1ns/100ps
// Converter stand-in: one done per start, latency chosen by the bench
module afss_adc_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire afss_pkg::afss_req_t adc_req,
    input wire logic [3:0] lat,
    output logic adc_done,
    output logic [afss_pkg::AFSS_DW-1:0] adc_data
);
    import afss_pkg::*;
    logic busy;
    logic [3:0] cnt;
    logic [AFSS_CHW-1:0] ch;
    logic [AFSS_DW-1:0] junk;
    // Data churns outside the done cycle, so a stale sample never looks valid
    assign adc_data = adc_done ? {ch, 8'h3C} : junk;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy <= 1'b0;
            cnt <= 4'h0;
            ch <= 4'h0;
            adc_done <= 1'b0;
            junk <= 12'hA5A;
        end else begin
            adc_done <= 1'b0;
            junk <= ~junk + 12'h001;
            if (adc_req.start) begin
                busy <= 1'b1;
                cnt <= lat;
                ch <= adc_req.channel;
            end else if (busy && cnt == 4'h0) begin
                busy <= 1'b0;
                adc_done <= 1'b1;
            end else if (busy) begin
                cnt <= cnt - 4'h1;
            end
        end
    end
endmodule

// >>> tb/testbench.sv
`timescale 1ns/100ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin num_errors++; \
    $display("[ERR] %0t got %0h exp %0h", $time, (g), (e)); end end
module testbench;
    import afss_pkg::*;
    localparam logic [31:0] RUN = 32'h1 << AFSS_CTRL_RUN;
    localparam logic [31:0] FIFO = 32'h1 << AFSS_CTRL_FIFO;
    localparam logic [31:0] SCAN = 32'h1 << AFSS_CTRL_SCAN;
    localparam logic [31:0] RCY = 32'h1 << AFSS_CTRL_RECYCLE;
    localparam logic [31:0] CAN = 32'h1 << AFSS_CTRL_CANCEL;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic conv_trig = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, irq, adc_done, err;
    logic [AFSS_DW-1:0] adc_data;
    logic [3:0] lat = 4'h0;
    afss_req_t adc_req;
    int num_errors = 0;
    int checks = 0;
    logic [31:0] hbuf [4];
    int hidx = 0;
    always #20 pclk = ~pclk;
    afss_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .conv_trig(conv_trig), .adc_req(adc_req),
        .adc_done(adc_done), .adc_data(adc_data), .irq(irq));
    afss_adc_model CONV (.pclk(pclk), .presetn(presetn), .adc_req(adc_req), .lat(lat),
        .adc_done(adc_done), .adc_data(adc_data));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Read before the edge updates it, as the slave samples it
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin num_errors++; tally_and_finish(); end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(rd & m, e)
    endtask
    task automatic trig();
        @(posedge pclk);
        conv_trig <= 1'b1;
        @(posedge pclk);
        conv_trig <= 1'b0;
    endtask
    task automatic wait_irq();
        int n;
        for (n = 0; n < 300; n++) begin @(negedge pclk); if (irq === 1'b1) break; end
        if (n >= 300) begin num_errors++; tally_and_finish(); end
    endtask
    task automatic wait_lvl(input logic [4:0] c);
        int n;
        for (n = 0; n < 40; n++) begin
            apb(1'b0, AFSS_OFS_LEVEL, 32'h0);
            if (rd[4:0] === c && rd[AFSS_LEVEL_BUSY] === 1'b0) break;
        end
        if (n >= 40) begin num_errors++; tally_and_finish(); end
    endtask
    task automatic chk_irq(input logic e);
        @(negedge pclk);
        `CHK(irq, e)
    endtask
    // Host drain: consecutive channels from c, into a buffer twice the threshold
    task automatic drain(input int cnt, input logic [3:0] c);
        for (int i = 0; i < cnt; i++) begin
            apb(1'b0, AFSS_OFS_DATA, 32'h0);
            `CHK(rd & 32'h000F0FFF, {12'h000, c + 4'(i), 4'h0, c + 4'(i), 8'h3C})
            hbuf[hidx] = rd;
            hidx = (hidx + 1) % 4;
        end
    endtask
    task automatic setup(input logic [31:0] rng, thr, msk, ctl);
        apb(1'b1, AFSS_OFS_CTRL, CAN);
        apb(1'b1, AFSS_OFS_STATUS, 32'hF);
        apb(1'b1, AFSS_OFS_RANGE, rng);
        apb(1'b1, AFSS_OFS_THRESH, thr);
        apb(1'b1, AFSS_OFS_MASK, msk);
        apb(1'b1, AFSS_OFS_CTRL, ctl);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        logic [7:0] ofs [6];
        ofs = '{AFSS_OFS_CTRL, AFSS_OFS_RANGE, AFSS_OFS_THRESH, AFSS_OFS_STATUS,
            AFSS_OFS_MASK, AFSS_OFS_LEVEL};
        foreach (ofs[i]) rchk(ofs[i], 32'hFFFFFFFF, 32'h0);
        apb(1'b0, 8'h1C, 32'h0);
        `CHK({err, rd}, {1'b1, 32'h0})
    endtask
    task automatic t_single_nobuf();
        logic [3:0] c;
        setup(32'h0302, 32'h0, 32'h1, RUN);
        for (int i = 0; i < 3; i++) begin
            c = 4'h2 + 4'(i % 2);
            trig();
            wait_irq();
            rchk(AFSS_OFS_STATUS, 32'hF, 32'h1);
            rchk(AFSS_OFS_LEVEL, 32'h000F001F, {12'h000, c ^ 4'h1, 16'h0001});
            drain(1, c);
            apb(1'b1, AFSS_OFS_STATUS, 32'h1);
            chk_irq(1'b0);
        end
    endtask
    task automatic t_scan_nobuf();
        setup(32'h0301, 32'h0, 32'h2, RUN | SCAN);
        lat <= 4'h3;
        trig();
        wait_irq();
        rchk(AFSS_OFS_LEVEL, 32'h0300001F, 32'h3);
        drain(3, 4'h1);
        apb(1'b1, AFSS_OFS_STATUS, 32'h2);
        chk_irq(1'b0);
    endtask
    task automatic t_scan_buf();
        setup(32'h0301, 32'h2, 32'h4, RUN | FIFO | SCAN);
        lat <= 4'h5;
        trig();
        wait_irq();
        rchk(AFSS_OFS_LEVEL, 32'h0300001F, 32'h3);
        rchk(AFSS_OFS_STATUS, 32'hF, 32'h4);
        drain(2, 4'h1);
        apb(1'b1, AFSS_OFS_STATUS, 32'h4);
        chk_irq(1'b0);
        drain(1, 4'h3);
    endtask
    task automatic t_single_buf();
        setup(32'h0504, 32'h2, 32'h4, RUN | FIFO);
        lat <= 4'h0;
        trig();
        wait_lvl(5'h01);
        chk_irq(1'b0);
        trig();
        wait_irq();
        apb(1'b1, AFSS_OFS_STATUS, 32'h4);
        chk_irq(1'b1);
        drain(2, 4'h4);
        `CHK(hbuf[(hidx + 2) % 4] & 32'h000F0000, 32'h00040000)
        apb(1'b1, AFSS_OFS_STATUS, 32'h4);
        chk_irq(1'b0);
        apb(1'b1, AFSS_OFS_CTRL, 32'h0);
        trig();
        rchk(AFSS_OFS_LEVEL, 32'h0100001F, 32'h0);
    endtask
    task automatic t_overrun_cancel();
        setup(32'h0302, 32'h0, 32'h8, RUN | RCY);
        rchk(AFSS_OFS_CTRL, 32'h1F, RUN | RCY);
        lat <= 4'h8;
        trig();
        trig();
        wait_irq();
        rchk(AFSS_OFS_STATUS, 32'h8, 32'h8);
        wait_lvl(5'h01);
        apb(1'b1, AFSS_OFS_CTRL, RUN | CAN);
        rchk(AFSS_OFS_LEVEL, 32'h000F001F, 32'h00020000);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_single_nobuf();
        t_scan_nobuf();
        t_scan_buf();
        t_single_buf();
        t_overrun_cancel();
        tally_and_finish();
    end
endmodule
